// ===== logic/sp_driver.sv
// Core of the 32-stage serial-in, parallel-out open-drain display driver.
// Assumes all pins but MCLK and RESET_N are asynchronous to MCLK and that the controller keeps its timing.
`timescale 1ns/10ps
`include "sp_consts.svh"

module sp_driver #(
  parameter int FIFO_DEPTH = `SP_FIFO_DEPTH
) (
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  input  wire logic                  SCLK,
  input  wire logic                  SDATA,
  input  wire logic                  LATCH_TRANSFER_N,
  input  wire logic                  OUTPUT_MASK_N,
  input  wire logic                  INVERT_SEL_N,
  input  wire logic                  HOLD_UPDATE,
  output logic                       SDO,
  output logic [`SP_STAGES-1:0]      DRIVE_OUTPUTS_O,
  output logic [`SP_STAGES-1:0]      DRIVE_OUTPUTS_OE,
  output logic                       OVERRUN
);
  localparam int EW = $bits(sp_pkg::sp_event_s);

  // Edge detection needs each serial clock phase to span at least two samples.
  if (`SP_CLK_WIDTH_CYC < `SP_SYNC_DEPTH) begin : g_rate_check
    $error("sp_driver clock too slow for the serial clock phase width");
  end
  if (FIFO_DEPTH < 2) begin : g_depth_check
    $error("sp_driver fifo depth must be at least 2");
  end

  sp_pkg::sp_state_s  st_reg;
  sp_pkg::sp_state_s  st_next;
  sp_pkg::sp_event_s  push_ev;
  sp_pkg::sp_event_s  pop_ev;
  logic               sclk_fall;
  logic               latch_change;
  logic               pop_fire;
  sp_pkg::sp_bits_t   sh_shifted;

  sp_stream_if #(.WIDTH(EW)) push_if ();
  sp_stream_if #(.WIDTH(EW)) pop_if ();

  // Events are queued so that shifts and latch transfers keep their order.
  sp_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .fill  (push_if),
    .drain (pop_if)
  );

  assign sclk_fall    = st_reg.sclk_prev & ~st_reg.sclk_sync[1];
  assign latch_change = st_reg.latch_prev ^ st_reg.latch_sync[1];

  always_comb begin
    push_ev             = '0;
    push_ev.shift_valid = sclk_fall;
    push_ev.shift_bit   = st_reg.data_sync[1];
    push_ev.latch_level = st_reg.latch_sync[1];
  end

  assign push_if.valid = sclk_fall | latch_change;
  assign push_if.data  = push_ev;
  assign pop_ev        = sp_pkg::sp_event_s'(pop_if.data);
  // Freezing the drain lets the queue fill; a full queue then drops events.
  assign pop_if.ready  = ~st_reg.hold_sync[1];
  assign pop_fire      = pop_if.valid & pop_if.ready;
  assign sh_shifted    = {st_reg.shreg[`SP_STAGES-2:0], pop_ev.shift_bit};

  always_comb begin
    st_next = st_reg;
    st_next.sclk_sync  = {st_reg.sclk_sync[0], SCLK};
    st_next.data_sync  = {st_reg.data_sync[0], SDATA};
    st_next.latch_sync = {st_reg.latch_sync[0], LATCH_TRANSFER_N};
    st_next.mask_sync  = {st_reg.mask_sync[0], OUTPUT_MASK_N};
    st_next.inv_sync   = {st_reg.inv_sync[0], INVERT_SEL_N};
    st_next.hold_sync  = {st_reg.hold_sync[0], HOLD_UPDATE};
    st_next.sclk_prev  = st_reg.sclk_sync[1];
    st_next.latch_prev = st_reg.latch_sync[1];
    st_next.sink_level = 1'b0;
    if (push_if.valid && !push_if.ready) begin
      st_next.overrun = 1'b1;
    end
    if (pop_fire) begin
      if (pop_ev.shift_valid) begin
        st_next.shreg = sh_shifted;
      end
      st_next.latch_level = pop_ev.latch_level;
    end
    if (st_next.latch_level) begin
      st_next.latches = st_next.shreg;
    end
    st_next.sdo = st_next.shreg[`SP_STAGES-1];
    st_next.drive_oe = sp_pkg::sp_drive_bits(st_next.latches,
                                             st_reg.mask_sync[1],
                                             st_reg.inv_sync[1]);
  end

  // Reset only gives the data a known start; it is not meaningful until loaded.
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st_reg           <= '0;
      // Mask and polarity start at their idle level, so no output turns on after reset.
      st_reg.mask_sync <= `SP_CTRL_IDLE;
      st_reg.inv_sync  <= `SP_CTRL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SDO              = st_reg.sdo;
  assign DRIVE_OUTPUTS_O  = {`SP_STAGES{st_reg.sink_level}};
  assign DRIVE_OUTPUTS_OE = st_reg.drive_oe;
  assign OVERRUN          = st_reg.overrun;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  a_shift_only_fall: assert property (
    !(pop_fire && pop_ev.shift_valid) |=> $stable(st_reg.shreg))
    else $error("shift register moved without a clock fall");

  a_shift_stage: assert property (
    pop_fire && pop_ev.shift_valid |=> st_reg.shreg == $past(sh_shifted))
    else $error("shift stage did not take its predecessor");

  a_sdo_last: assert property (
    SDO == st_reg.shreg[`SP_STAGES-1])
    else $error("serial output differs from last stage");

  a_fall_queued: assert property (
    sclk_fall |-> push_if.valid && push_ev.shift_valid)
    else $error("clock fall was not queued");

  a_latch_follow: assert property (
    st_reg.latch_level |-> st_reg.latches == st_reg.shreg)
    else $error("transparent latches differ from shift register");

  a_latch_hold: assert property (
    !st_reg.latch_level && !(pop_fire && pop_ev.latch_level) |=> $stable(st_reg.latches))
    else $error("latches changed while holding");

  a_latch_load: assert property (
    $rose(st_reg.latch_level) |-> st_reg.latches == $past(st_next.shreg))
    else $error("latch transfer did not load shift register");

  a_all_on: assert property (
    !st_reg.mask_sync[1] && !st_reg.inv_sync[1] |=> DRIVE_OUTPUTS_OE == '1)
    else $error("masked outputs not all on");

  a_all_off: assert property (
    !st_reg.mask_sync[1] && st_reg.inv_sync[1] |=> DRIVE_OUTPUTS_OE == '0)
    else $error("masked outputs not all off");

  a_drive_direct: assert property (
    st_reg.mask_sync[1] && st_reg.inv_sync[1] |=> DRIVE_OUTPUTS_OE == st_reg.latches)
    else $error("outputs do not follow latches");

  a_drive_invert: assert property (
    st_reg.mask_sync[1] && !st_reg.inv_sync[1] |=> DRIVE_OUTPUTS_OE == ~st_reg.latches)
    else $error("outputs not inverted in invert mode");

  a_overrun_sticky: assert property (
    st_reg.overrun |=> st_reg.overrun)
    else $error("overrun flag cleared without reset");

  a_first_stage: assert property (
    pop_fire && pop_ev.shift_valid |=> st_reg.shreg[0] == $past(pop_ev.shift_bit))
    else $error("first stage did not take the data bit");

  a_sdo_follow: assert property (
    pop_fire && pop_ev.shift_valid |=> SDO == $past(st_reg.shreg[`SP_STAGES-2]))
    else $error("serial output did not move with the shift");

  // With the queue empty and draining, a detected fall reaches the first stage in two cycles.
  a_fall_to_stage: assert property (
    sclk_fall && !pop_if.valid && !st_reg.hold_sync[0] && !st_reg.hold_sync[1]
    |-> ##2 st_reg.shreg[0] == $past(push_ev.shift_bit, 2))
    else $error("clock fall did not reach the first stage");

  a_hold_freezes: assert property (
    st_reg.hold_sync[1] |=> $stable(st_reg.shreg) && $stable(st_reg.latch_level))
    else $error("state moved while the queue was frozen");

  a_level_popped: assert property (
    pop_fire |=> st_reg.latch_level == $past(pop_ev.latch_level))
    else $error("latch level not taken from the queue");

  a_overrun_set: assert property (
    push_if.valid && !push_if.ready |=> OVERRUN)
    else $error("dropped event did not raise overrun");

  a_sink_low: assert property (
    DRIVE_OUTPUTS_O == '0)
    else $error("open drain value not low");

  // Outputs may only move with the latches or with a settled mask or polarity change.
  a_out_hold: assert property (
    !st_reg.latch_level && !(pop_fire && pop_ev.latch_level)
    && $stable(st_reg.mask_sync[1]) && $stable(st_reg.inv_sync[1])
    |=> $stable(DRIVE_OUTPUTS_OE))
    else $error("outputs changed while latches held");

  a_mask_override: assert property (
    !st_reg.mask_sync[1] |=> DRIVE_OUTPUTS_OE == {`SP_STAGES{!$past(st_reg.inv_sync[1])}})
    else $error("masked outputs ignore polarity select");

endmodule // sp_driver

// ===== pkg/sp_consts.svh
// Constants of the 32-stage serial-in, parallel-out display driver.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH

// Number of shift stages, latches and drive outputs.
`define SP_STAGES 32
// Flip-flops in each pin synchroniser.
`define SP_SYNC_DEPTH 2
// Default depth of the event FIFO.
`define SP_FIFO_DEPTH 32
// Controller clock period, used only to derive the cycle figures below.
`define SP_MCLK_PERIOD_NS 40
// Shortest serial clock phase that the controller keeps.
`define SP_CLK_WIDTH_NS 62
// The same phase in MCLK cycles, rounded up as a least time.
`define SP_CLK_WIDTH_CYC ((`SP_CLK_WIDTH_NS + `SP_MCLK_PERIOD_NS - 1) / `SP_MCLK_PERIOD_NS)
// Reset value of every shift stage, latch and drive enable.
`define SP_BITS_RESET 32'h0000_0000
// Reset value of the clock, data, latch and hold synchronisers and the edge detectors.
`define SP_SYNC_RESET 2'h0
// Reset value of the mask and polarity synchronisers: both inputs idle high.
`define SP_CTRL_IDLE 2'h3

`endif

// ===== pkg/sp_pkg.sv
// Types shared by the driver core and its testbench.
// Assumes sp_consts.svh is on the include path.
`include "sp_consts.svh"

package sp_pkg;

  typedef logic [`SP_STAGES-1:0]     sp_bits_t;
  typedef logic [`SP_SYNC_DEPTH-1:0] sp_sync_t;

  // One entry per serial clock fall or latch-transfer level change.
  typedef struct packed {
    logic shift_valid;
    logic shift_bit;
    logic latch_level;
  } sp_event_s;

  typedef struct packed {
    sp_sync_t sclk_sync;
    sp_sync_t data_sync;
    sp_sync_t latch_sync;
    sp_sync_t mask_sync;
    sp_sync_t inv_sync;
    sp_sync_t hold_sync;
    logic     sclk_prev;
    logic     latch_prev;
    sp_bits_t shreg;
    sp_bits_t latches;
    logic     latch_level;
    sp_bits_t drive_oe;
    logic     sink_level;
    logic     sdo;
    logic     overrun;
  } sp_state_s;

  // Drive enables from latch contents, output mask and polarity select.
  function automatic sp_bits_t sp_drive_bits(sp_bits_t latches, logic mask_n, logic inv_n);
    sp_bits_t r;
    r = '0;
    if (!mask_n) begin
      r = inv_n ? '0 : '1;
    end else begin
      r = inv_n ? latches : ~latches;
    end
    return r;
  endfunction

endpackage

// ===== pkg/sp_stream_if.sv
// Valid/ready stream between the driver core and its event FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface sp_stream_if #(
  parameter int WIDTH = 3
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sp_stream_if

// ===== logic/sp_fifo.sv
// Synchronous show-ahead FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "sp_consts.svh"

module sp_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = `SP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  sp_stream_if.snk fill,
  sp_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } sp_fifo_state_s;

  // Pointers wrap by overflow, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("sp_fifo depth must be a power of two of at least 2");
  end

  sp_fifo_state_s st_reg;
  sp_fifo_state_s st_next;
  logic           push;
  logic           pop;

  assign fill.ready  = (st_reg.count != DEPTH[AW:0]);
  assign drain.valid = (st_reg.count != '0);
  assign drain.data  = st_reg.mem[st_reg.rd_ptr];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = fill.data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.count <= DEPTH[AW:0]) else $error("fifo count beyond depth");

endmodule // sp_fifo

// ===== testbench/sp_ctrl_model.sv
// Behavioural display controller that drives the driver's serial pins.
// Assumes one free-running system clock; pins change just after its rise.
`timescale 1ns/10ps

module sp_ctrl_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      latch_n
);
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
    latch_n = 1'b0;
  end

  // Phases of 3 or more cycles keep well clear of the minimum width.
  task automatic shift_bit(input logic b);
    @(posedge clk);
    sdata <= b;
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    sclk <= 1'b1;
    // Outside its hold time the data line shows no stale value.
    sdata <= ~b;
  endtask

  task automatic latch_pulse();
    repeat (3) @(posedge clk);
    latch_n <= 1'b1;
    repeat (3) @(posedge clk);
    latch_n <= 1'b0;
  endtask

  task automatic set_latch(input logic v);
    @(posedge clk);
    latch_n <= v;
  endtask
endmodule // sp_ctrl_model

// ===== testbench/tb_top.sv
// Self-checking bench for the serial-in, parallel-out driver.
// Assumes the controller model drives the serial pins and the bench the rest.
`timescale 1ns/10ps

module tb_top;
  logic             mclk;
  logic             reset_n;
  logic             mask_n;
  logic             inv_n;
  logic             hold;
  logic             sclk;
  logic             sdata;
  logic             latch_n;
  logic             sdo;
  logic             overrun;
  sp_pkg::sp_bits_t oe;
  sp_pkg::sp_bits_t o;
  sp_pkg::sp_bits_t sh;
  sp_pkg::sp_bits_t lat;
  logic [31:0]      seed;
  int               mismatches;
  int               num_checks;
  int               cycles = 0;

  sp_driver dut_u (
    .MCLK(mclk), .RESET_N(reset_n), .SCLK(sclk), .SDATA(sdata),
    .LATCH_TRANSFER_N(latch_n), .OUTPUT_MASK_N(mask_n),
    .INVERT_SEL_N(inv_n), .HOLD_UPDATE(hold), .SDO(sdo),
    .DRIVE_OUTPUTS_O(o), .DRIVE_OUTPUTS_OE(oe), .OVERRUN(overrun)
  );

  sp_ctrl_model ctl_u (.clk(mclk), .sclk(sclk), .sdata(sdata), .latch_n(latch_n));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic sp_pkg::sp_bits_t exp_oe(sp_pkg::sp_bits_t l, logic m, logic p);
    if (!m) return {32{~p}};
    return p ? l : ~l;
  endfunction

  task automatic chk_bits(input sp_pkg::sp_bits_t g, input sp_pkg::sp_bits_t e, input string s);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string s);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %b exp %b", $time, s, g, e);
    end
  endtask

  task automatic settle();
    repeat (10) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic put_bit(input logic b, input logic keep);
    ctl_u.shift_bit(b);
    if (keep) sh = {sh[30:0], b};
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    mask_n = 1'b1;
    inv_n = 1'b1;
    hold = 1'b0;
    seed = 32'h5a3e50b1;
    mismatches = 0;
    num_checks = 0;
    sh = '0;
    lat = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    settle();
    chk_bits(oe, 32'h0000_0000, "reset oe");
    chk_bits(o, 32'h0000_0000, "open drain value");
    // Shift under every mask and polarity pairing, latches holding.
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      mask_n <= k[1];
      inv_n <= k[0];
      seed = lfsr(seed);
      for (int i = 31; i >= 0; i--) put_bit(seed[i], 1'b1);
      settle();
      chk_bits(oe, exp_oe(lat, mask_n, inv_n), "latch hold");
      chk_bit(sdo, seed[31], "last stage");
      chk_bits(dut_u.st_reg.shreg, seed, "shift register");
      ctl_u.latch_pulse();
      lat = sh;
      for (int j = 3; j >= 0; j--) begin
        @(posedge mclk);
        mask_n <= j[1];
        inv_n <= j[0];
        settle();
        chk_bits(oe, exp_oe(lat, mask_n, inv_n), "mode");
      end
    end
    ctl_u.set_latch(1'b1);
    mask_n <= 1'b1;
    inv_n <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      put_bit(seed[0], 1'b1);
      settle();
      chk_bit(sdo, sh[31], "stage chain");
      chk_bits(oe, sh, "transparent");
    end
    ctl_u.set_latch(1'b0);
    // Let the latch event drain first, so the frozen queue holds shifts only.
    repeat (10) @(posedge mclk);
    hold <= 1'b1;
    seed = lfsr(seed);
    for (int i = 0; i < 34; i++) put_bit(seed[i % 32], i < 32);
    settle();
    chk_bit(overrun, 1'b1, "queue refused");
    @(posedge mclk);
    hold <= 1'b0;
    // One entry drains per cycle, so wait for all 32.
    repeat (4) settle();
    chk_bit(sdo, sh[31], "queue drained");
    ctl_u.latch_pulse();
    settle();
    chk_bits(oe, sh, "drained load");
    end_sim();
  end
endmodule // tb_top
